// ===== pkg/qer_pkg.sv
// Shared constants for the quadrature readout link, both ends
// Behaviour
// RULE1: Motor-one position read sends address, code, no checksum
// RULE2: Position answer is six bytes, count MSB first
// RULE3: Position counter is unsigned 32-bit, steps per pulse
// RULE4: Underflow flag set on wrap, cleared when returned
// RULE5: Direction bit: zero forward, one backward
// RULE6: Overflow flag set on wrap, cleared when returned
// RULE7: Bit 7 encoder ok; bits 3-6 reserved
// RULE8: Every read answer ends with a checksum
// RULE9: Checksum is byte sum masked to seven bits
// RULE10: Code 17 reads motor-two position and status
// RULE11: Codes 18/19 read pulses per second
// RULE12: Speed answer fifth byte is direction, then checksum
// RULE13: Code 20 clears both counters, needs checksum
// RULE14: Gain load sends D, P, I, rate in order
// RULE15: Each constant is four bytes, MSB first
// RULE16: Host appends checksum to every gain load
// RULE17: Reset restores default proportional, integral, derivative gains
// RULE18: Default full-speed pulse rate is 44000
// RULE19: Codes 30/31 read pulses in last 1/125 s
// RULE20: Fast speed answer is four bytes plus checksum
// RULE21: Bad checksum write is discarded, nothing changes
package qer_pkg;
  localparam logic [7:0] CMD_POS1 = 8'h10;
  localparam logic [7:0] CMD_POS2 = 8'h11;
  localparam logic [7:0] CMD_SPD1 = 8'h12;
  localparam logic [7:0] CMD_SPD2 = 8'h13;
  localparam logic [7:0] CMD_CLR = 8'h14;
  localparam logic [7:0] CMD_PID1 = 8'h1C;
  localparam logic [7:0] CMD_PID2 = 8'h1D;
  localparam logic [7:0] CMD_HSP1 = 8'h1E;
  localparam logic [7:0] CMD_HSP2 = 8'h1F;
  localparam logic [7:0] CRC_MASK = 8'h7F;
  localparam logic [7:0] DEF_UNIT_ADDR = 8'h80;
  localparam int ST_UNDER = 0;
  localparam int ST_DIR = 1;
  localparam int ST_OVER = 2;
  localparam int ST_OK = 7;
  localparam logic [31:0] DEF_P = 32'h0000_0200;
  localparam logic [31:0] DEF_I = 32'h0000_0100;
  localparam logic [31:0] DEF_D = 32'h0000_0080;
  localparam logic [31:0] DEF_RATE = 32'd44000;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam int CLK_HZ = 125_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int HSP_DIV = 125;
  localparam int HSP_CYC = CLK_HZ / HSP_DIV;
  localparam logic [4:0] PAY_LAST = 5'd15;
  localparam logic [4:0] LEN_LONG = 5'd6;
  localparam logic [4:0] LEN_SHORT = 5'd5;
  localparam logic [4:0] LEN_PID = 5'd19;
  localparam logic [4:0] LEN_CLR = 5'd3;
  localparam logic [4:0] LEN_READ = 5'd2;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX0 = 8'h04;
  localparam logic [7:0] OFS_TX1 = 8'h08;
  localparam logic [7:0] OFS_TX2 = 8'h0C;
  localparam logic [7:0] OFS_TX3 = 8'h10;
  localparam logic [7:0] OFS_RXVAL = 8'h14;
  localparam logic [7:0] OFS_RXINFO = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CRCERR = 2;
endpackage : qer_pkg

// ===== pkg/qer_link_if.sv
// Byte link between the host end and the readout device
interface qer_link_if (
  input wire logic pclk
);
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic [7:0] d2h_data;
  logic d2h_valid;
  modport dev (input pclk, input h2d_data, input h2d_valid, output d2h_data, output d2h_valid);
  modport host (input pclk, output h2d_data, output h2d_valid, input d2h_data, input d2h_valid);
endinterface : qer_link_if

// ===== core/qer_dev.sv
// Device end: encoder counters, speed capture, command parser
//
// Our own choices: the register offsets and the APB slave port.
module qer_dev
  import qer_pkg::*;
#(
  parameter logic [7:0] UNIT_ADDR = DEF_UNIT_ADDR,
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int HSP_CYCLES = HSP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  qer_link_if.dev link,
  input wire logic [1:0] enc_a,
  input wire logic [1:0] enc_b,
  input wire logic [1:0] enc_ok,
  output logic [1:0][31:0] gain_p,
  output logic [1:0][31:0] gain_i,
  output logic [1:0][31:0] gain_d,
  output logic [1:0][31:0] full_speed_pulse_rate
);
  typedef enum logic [2:0] {S_ADDR, S_CMD, S_PAY, S_CRC, S_SEND} qer_dst_t;
  logic [5:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
  logic [5:0] raw;
  logic [1:0] a_prev_r, b_prev_r;
  logic [1:0][31:0] cnt_r, cnt_nxt, sec_acc_r, sec_acc_nxt, sec_val_r, sec_val_nxt;
  logic [1:0][31:0] hsp_acc_r, hsp_acc_nxt, hsp_val_r, hsp_val_nxt;
  logic [1:0] under_r, under_nxt, over_r, over_nxt, dir_r, dir_nxt;
  logic [1:0] st_clr, cnt_clr;
  logic [31:0] sec_tmr_r, sec_tmr_nxt, hsp_tmr_r, hsp_tmr_nxt;
  logic sec_tick, hsp_tick;
  qer_dst_t st_r, st_nxt;
  logic [7:0] cmd_r, cmd_nxt, sum_r, sum_nxt, txd_r, txd_nxt;
  logic txv_r, txv_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [127:0] pay_r, pay_nxt;
  logic [39:0] tx_r, tx_nxt;
  logic [1:0][31:0] gp_r, gp_nxt, gi_r, gi_nxt, gd_r, gd_nxt, gq_r, gq_nxt;

  assign raw = {enc_ok, enc_b, enc_a};
  // Pins settle through three stages; a change counts once two agree
  always_comb begin
    flt_nxt = flt_r;
    for (int k = 0; k < 6; k++) begin
      if (s2_r[k] == s3_r[k]) begin
        flt_nxt[k] = s3_r[k];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
      a_prev_r <= '0;
      b_prev_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
      a_prev_r <= flt_r[1:0];
      b_prev_r <= flt_r[3:2];
    end
  end

  // Free-running sample windows shared by both channels
  always_comb begin
    sec_tick = (sec_tmr_r == 32'(SEC_CYCLES - 1));
    hsp_tick = (hsp_tmr_r == 32'(HSP_CYCLES - 1));
    sec_tmr_nxt = sec_tick ? '0 : sec_tmr_r + 32'd1;
    hsp_tmr_nxt = hsp_tick ? '0 : hsp_tmr_r + 32'd1;
  end

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic ea, eb, chg, up;
      assign ea = flt_r[c];
      assign eb = flt_r[2 + c];
      // A double transition is a lost step, not a pulse
      assign chg = (ea ^ a_prev_r[c]) ^ (eb ^ b_prev_r[c]);
      assign up = ea ^ b_prev_r[c];
      always_comb begin
        cnt_nxt[c] = cnt_r[c];
        under_nxt[c] = st_clr[c] ? 1'b0 : under_r[c]; // [RULE4]
        over_nxt[c] = st_clr[c] ? 1'b0 : over_r[c]; // [RULE6]
        dir_nxt[c] = dir_r[c];
        sec_acc_nxt[c] = sec_acc_r[c];
        hsp_acc_nxt[c] = hsp_acc_r[c];
        if (chg) begin
          dir_nxt[c] = ~up; // [RULE5]
          sec_acc_nxt[c] = sec_acc_r[c] + 32'd1;
          hsp_acc_nxt[c] = hsp_acc_r[c] + 32'd1;
          if (up) begin
            cnt_nxt[c] = cnt_r[c] + 32'd1; // [RULE3]
            if (cnt_r[c] == CNT_MAX) begin
              over_nxt[c] = 1'b1; // [RULE6]
            end
          end else begin
            cnt_nxt[c] = cnt_r[c] - 32'd1; // [RULE3]
            if (cnt_r[c] == '0) begin
              under_nxt[c] = 1'b1; // [RULE4]
            end
          end
        end
        if (cnt_clr[c]) begin
          cnt_nxt[c] = '0; // [RULE13]
        end
        sec_val_nxt[c] = sec_tick ? sec_acc_nxt[c] : sec_val_r[c]; // [RULE11]
        hsp_val_nxt[c] = hsp_tick ? hsp_acc_nxt[c] : hsp_val_r[c]; // [RULE19]
        if (sec_tick) begin
          sec_acc_nxt[c] = '0;
        end
        if (hsp_tick) begin
          hsp_acc_nxt[c] = '0;
        end
      end
    end
  endgenerate

  function automatic logic [7:0] status_of(input int c, input logic [1:0] un, input logic [1:0] ov,
                                           input logic [1:0] dr, input logic [5:0] f);
    logic [7:0] s;
    s = '0; // [RULE7]
    s[ST_UNDER] = un[c];
    s[ST_DIR] = dr[c];
    s[ST_OVER] = ov[c];
    s[ST_OK] = f[4 + c];
    return s;
  endfunction : status_of

  // Parser: address, code, payload, checksum; answers are sent back to back
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    sum_nxt = sum_r;
    idx_nxt = idx_r;
    pay_nxt = pay_r;
    tx_nxt = tx_r;
    txd_nxt = 8'h00;
    txv_nxt = 1'b0;
    st_clr = '0;
    cnt_clr = '0;
    gp_nxt = gp_r;
    gi_nxt = gi_r;
    gd_nxt = gd_r;
    gq_nxt = gq_r;
    unique case (st_r)
      S_ADDR: begin
        if (link.h2d_valid && link.h2d_data == UNIT_ADDR) begin
          sum_nxt = link.h2d_data;
          st_nxt = S_CMD;
        end
      end
      S_CMD: begin
        if (link.h2d_valid) begin
          cmd_nxt = link.h2d_data;
          sum_nxt = sum_r + link.h2d_data; // [RULE9]
          idx_nxt = LEN_LONG;
          st_nxt = S_SEND;
          unique case (link.h2d_data)
            CMD_POS1: begin
              tx_nxt = {cnt_r[0], status_of(0, under_r, over_r, dir_r, flt_r)}; // [RULE2]
              st_clr[0] = 1'b1; // [RULE4] [RULE6]
            end
            CMD_POS2: begin
              tx_nxt = {cnt_r[1], status_of(1, under_r, over_r, dir_r, flt_r)}; // [RULE10]
              st_clr[1] = 1'b1; // [RULE4] [RULE6]
            end
            CMD_SPD1: tx_nxt = {sec_val_r[0], 7'h00, dir_r[0]}; // [RULE11] [RULE12]
            CMD_SPD2: tx_nxt = {sec_val_r[1], 7'h00, dir_r[1]}; // [RULE11] [RULE12]
            CMD_HSP1: begin
              tx_nxt = {hsp_val_r[0], 8'h00}; // [RULE19]
              idx_nxt = LEN_SHORT; // [RULE20]
            end
            CMD_HSP2: begin
              tx_nxt = {hsp_val_r[1], 8'h00}; // [RULE19]
              idx_nxt = LEN_SHORT; // [RULE20]
            end
            CMD_CLR: st_nxt = S_CRC; // [RULE13]
            CMD_PID1, CMD_PID2: begin
              idx_nxt = '0;
              st_nxt = S_PAY;
            end
            default: st_nxt = S_ADDR;
          endcase
        end
      end
      S_PAY: begin
        if (link.h2d_valid) begin
          pay_nxt = {pay_r[119:0], link.h2d_data}; // [RULE15]
          sum_nxt = sum_r + link.h2d_data;
          idx_nxt = idx_r + 5'd1;
          if (idx_r == PAY_LAST) begin
            st_nxt = S_CRC;
          end
        end
      end
      S_CRC: begin
        if (link.h2d_valid) begin
          st_nxt = S_ADDR;
          if (link.h2d_data == (sum_r & CRC_MASK)) begin // [RULE21]
            if (cmd_r == CMD_CLR) begin
              cnt_clr = 2'b11; // [RULE13]
            end else begin
              // Payload arrives D, P, I, rate
              gd_nxt[cmd_r == CMD_PID2] = pay_r[127:96]; // [RULE14]
              gp_nxt[cmd_r == CMD_PID2] = pay_r[95:64];
              gi_nxt[cmd_r == CMD_PID2] = pay_r[63:32];
              gq_nxt[cmd_r == CMD_PID2] = pay_r[31:0];
            end
          end
        end
      end
      S_SEND: begin
        // Link is half duplex; bytes arriving now are dropped
        txv_nxt = 1'b1;
        idx_nxt = idx_r - 5'd1;
        if (idx_r == 5'd1) begin
          txd_nxt = sum_r & CRC_MASK; // [RULE8] [RULE9]
          st_nxt = S_ADDR;
        end else begin
          txd_nxt = tx_r[39:32];
          sum_nxt = sum_r + tx_r[39:32];
          tx_nxt = {tx_r[31:0], 8'h00};
        end
      end
      default: st_nxt = S_ADDR;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      under_r <= '0;
      over_r <= '0;
      dir_r <= '0;
      sec_acc_r <= '0;
      sec_val_r <= '0;
      hsp_acc_r <= '0;
      hsp_val_r <= '0;
      sec_tmr_r <= '0;
      hsp_tmr_r <= '0;
      st_r <= S_ADDR;
      cmd_r <= '0;
      sum_r <= '0;
      idx_r <= '0;
      pay_r <= '0;
      tx_r <= '0;
      txd_r <= '0;
      txv_r <= 1'b0;
      gp_r <= {DEF_P, DEF_P}; // [RULE17]
      gi_r <= {DEF_I, DEF_I}; // [RULE17]
      gd_r <= {DEF_D, DEF_D}; // [RULE17]
      gq_r <= {DEF_RATE, DEF_RATE}; // [RULE18]
    end else begin
      cnt_r <= cnt_nxt;
      under_r <= under_nxt;
      over_r <= over_nxt;
      dir_r <= dir_nxt;
      sec_acc_r <= sec_acc_nxt;
      sec_val_r <= sec_val_nxt;
      hsp_acc_r <= hsp_acc_nxt;
      hsp_val_r <= hsp_val_nxt;
      sec_tmr_r <= sec_tmr_nxt;
      hsp_tmr_r <= hsp_tmr_nxt;
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      sum_r <= sum_nxt;
      idx_r <= idx_nxt;
      pay_r <= pay_nxt;
      tx_r <= tx_nxt;
      txd_r <= txd_nxt;
      txv_r <= txv_nxt;
      gp_r <= gp_nxt;
      gi_r <= gi_nxt;
      gd_r <= gd_nxt;
      gq_r <= gq_nxt;
    end
  end

  assign link.d2h_data = txd_r;
  assign link.d2h_valid = txv_r;
  assign gain_p = gp_r;
  assign gain_i = gi_r;
  assign gain_d = gd_r;
  assign full_speed_pulse_rate = gq_r;
endmodule : qer_dev

// ===== core/qer_host.sv
// Host end: APB register front, sends commands and collects answers
module qer_host
  import qer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  qer_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV} qer_hst_t;
  qer_hst_t st_r, st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [7:0] addr_r, addr_nxt, cmd_r, cmd_nxt, sum_r, sum_nxt, txd_r, txd_nxt;
  logic txv_r, txv_nxt;
  logic [3:0][31:0] txw_r, txw_nxt;
  logic [39:0] rx_r, rx_nxt;
  logic [4:0] idx_r, idx_nxt, len_r, len_nxt, rlen_r, rlen_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt;
  logic wr_acc, mapped;
  logic [127:0] pay;
  logic [7:0] byte_out;

  assign pay = {txw_r[0], txw_r[1], txw_r[2], txw_r[3]};
  assign mapped = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

  always_comb begin
    if (idx_r == '0) begin
      byte_out = addr_r;
    end else if (idx_r == 5'd1) begin
      byte_out = cmd_r;
    end else if (idx_r == len_r - 5'd1 && len_r != LEN_READ) begin
      byte_out = sum_r & CRC_MASK; // [RULE9] [RULE13] [RULE16]
    end else begin
      byte_out = pay[127 - 8 * (int'(idx_r) - 2) -: 8]; // [RULE14] [RULE15]
    end
  end

  always_comb begin
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !mapped;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_CTRL: prdata_nxt = {16'h0000, addr_r, cmd_r};
        OFS_TX0: prdata_nxt = txw_r[0];
        OFS_TX1: prdata_nxt = txw_r[1];
        OFS_TX2: prdata_nxt = txw_r[2];
        OFS_TX3: prdata_nxt = txw_r[3];
        OFS_RXVAL: prdata_nxt = rx_r[39:8];
        OFS_RXINFO: prdata_nxt = {24'h00_0000, rx_r[7:0]};
        OFS_STAT: prdata_nxt = {29'h0000_0000, err_r, done_r, busy_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    st_nxt = st_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    sum_nxt = sum_r;
    txw_nxt = txw_r;
    rx_nxt = rx_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    rlen_nxt = rlen_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    err_nxt = err_r;
    txd_nxt = 8'h00;
    txv_nxt = 1'b0;
    // Payload words are frozen while a command is on the wire
    if (wr_acc && !busy_r) begin
      unique case (paddr)
        OFS_TX0: txw_nxt[0] = pwdata;
        OFS_TX1: txw_nxt[1] = pwdata;
        OFS_TX2: txw_nxt[2] = pwdata;
        OFS_TX3: txw_nxt[3] = pwdata;
        default: ;
      endcase
    end
    unique case (st_r)
      H_IDLE: begin
        if (wr_acc && paddr == OFS_CTRL) begin
          addr_nxt = pwdata[15:8];
          cmd_nxt = pwdata[7:0];
          sum_nxt = '0;
          idx_nxt = '0;
          busy_nxt = 1'b1;
          done_nxt = 1'b0;
          err_nxt = 1'b0;
          st_nxt = H_SEND;
          unique case (pwdata[7:0])
            CMD_PID1, CMD_PID2: len_nxt = LEN_PID; // [RULE16]
            CMD_CLR: len_nxt = LEN_CLR; // [RULE13]
            default: len_nxt = LEN_READ; // [RULE1]
          endcase
          unique case (pwdata[7:0])
            CMD_POS1, CMD_POS2, CMD_SPD1, CMD_SPD2: rlen_nxt = LEN_LONG;
            CMD_HSP1, CMD_HSP2: rlen_nxt = LEN_SHORT;
            default: rlen_nxt = '0;
          endcase
        end
      end
      H_SEND: begin
        txd_nxt = byte_out;
        txv_nxt = 1'b1;
        sum_nxt = sum_r + byte_out;
        idx_nxt = idx_r + 5'd1;
        if (idx_r == len_r - 5'd1) begin
          idx_nxt = '0;
          if (rlen_r == '0) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = H_IDLE;
          end else begin
            st_nxt = H_RECV;
          end
        end
      end
      H_RECV: begin
        if (link.d2h_valid) begin
          idx_nxt = idx_r + 5'd1;
          if (idx_r == rlen_r - 5'd1) begin
            err_nxt = (link.d2h_data != (sum_r & CRC_MASK)); // [RULE8] [RULE9]
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = H_IDLE;
          end else begin
            rx_nxt = {rx_r[31:0], link.d2h_data}; // [RULE2] [RULE20]
            sum_nxt = sum_r + link.d2h_data;
            if (rlen_r == LEN_SHORT && idx_r == 5'd3) begin
              rx_nxt = {rx_r[23:0], link.d2h_data, 8'h00};
            end
          end
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= H_IDLE;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      addr_r <= DEF_UNIT_ADDR;
      cmd_r <= '0;
      sum_r <= '0;
      txd_r <= '0;
      txv_r <= 1'b0;
      txw_r <= '0;
      rx_r <= '0;
      idx_r <= '0;
      len_r <= '0;
      rlen_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      sum_r <= sum_nxt;
      txd_r <= txd_nxt;
      txv_r <= txv_nxt;
      txw_r <= txw_nxt;
      rx_r <= rx_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      rlen_r <= rlen_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link.h2d_data = txd_r;
  assign link.h2d_valid = txv_r;
endmodule : qer_host

// ===== tb/qer_link_sva.sv
// Link protocol checker for the readout byte link
module qer_link_sva
  import qer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hv_r;
  logic hv_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  // Frame sum; a host byte after a cycle with no host byte starts a new frame
  always_comb begin
    hv_nxt = h2d_valid;
    acc_nxt = acc_r;
    if (h2d_valid && !hv_r) begin
      acc_nxt = h2d_data;
    end else if (h2d_valid) begin
      acc_nxt = acc_r + h2d_data;
    end else if (d2h_valid) begin
      acc_nxt = acc_r + d2h_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_r <= 1'b0;
      acc_r <= 8'h00;
    end else begin
      hv_r <= hv_nxt;
      acc_r <= acc_nxt;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Command byte of a fresh frame; bit 0 picks the motor of a pair
  sequence cmd_s(logic [7:0] code);
    h2d_valid && h2d_data[7:1] == code[7:1] && $past(h2d_valid) && !$past(h2d_valid, 2)
      && $past(h2d_data) == DEF_UNIT_ADDR;
  endsequence
  sequence six_s;
    d2h_valid [*6] ##1 !d2h_valid;
  endsequence
  sequence five_s;
    d2h_valid [*5] ##1 !d2h_valid;
  endsequence
  pos_len_a: assert property (cmd_s(CMD_POS1) |-> ##2 six_s)
    else $error("position answer length wrong");
  spd_len_a: assert property (cmd_s(CMD_SPD1) |-> ##2 six_s)
    else $error("speed answer length wrong");
  fast_len_a: assert property (cmd_s(CMD_HSP1) |-> ##2 five_s)
    else $error("fast speed answer length wrong");
  stat_rsvd_a: assert property (cmd_s(CMD_POS1)
    |-> ##6 d2h_valid && d2h_data[6:3] == 4'h0) else $error("reserved status bits set");
  dir_byte_a: assert property (cmd_s(CMD_SPD1)
    |-> ##6 d2h_valid && d2h_data[7:1] == 7'h00) else $error("direction byte out of range");
  ans_crc_a: assert property ($fell(d2h_valid)
    |-> $past(d2h_data) == ($past(acc_r) & CRC_MASK)) else $error("answer checksum wrong");
  host_crc_a: assert property ($fell(h2d_valid)
    && $past(h2d_valid, 2) && $past(h2d_valid, 3)
    |-> $past(h2d_data) == ($past(acc_r) & CRC_MASK)) else $error("command checksum wrong");
  clr_quiet_a: assert property (cmd_s(CMD_CLR) |-> ##1 !d2h_valid [*8])
    else $error("answer after counter clear");
  rd_nocrc_a: assert property (cmd_s(CMD_POS1) |-> ##1 !h2d_valid)
    else $error("byte after read command");
  pid_len_a: assert property (cmd_s(CMD_PID1)
    |-> ##1 h2d_valid [*8] ##1 h2d_valid [*8] ##1 h2d_valid ##1 !h2d_valid)
    else $error("gain load frame length wrong");
endmodule : qer_link_sva

// ===== tb/tb_top.sv
// Testbench: host end and device end joined over the byte link
module tb_top
  import qer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SEC_T = 1000;
  localparam int HSP_T = 100;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, ri;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0] enc_a, enc_b, enc_ok, un, ov, dir;
  logic [1:0][31:0] gain_p, gain_i, gain_d, speed_rate, bp, bi, bd, br;
  logic [31:0] cnt [2];
  logic [31:0] gv [4];
  logic [1:0] ph [2];
  logic [127:0] pay;
  logic [31:0] seed = 32'h0000_cf4c;
  int n_mismatch = 0;
  int num_checks = 0;
  qer_link_if link (.pclk(pclk));
  qer_link_if link_b (.pclk(pclk));
  qer_host u_qer_host (.pclk(pclk), .presetn(presetn), .link(link.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  qer_dev #(.SEC_CYCLES(SEC_T), .HSP_CYCLES(HSP_T)) u_qer_dev (.pclk(pclk), .presetn(presetn),
    .link(link.dev), .enc_a(enc_a), .enc_b(enc_b), .enc_ok(enc_ok), .gain_p(gain_p),
    .gain_i(gain_i), .gain_d(gain_d), .full_speed_pulse_rate(speed_rate));
  // Second device driven straight by the bench to send corrupt and good frames
  qer_dev #(.SEC_CYCLES(SEC_T), .HSP_CYCLES(HSP_T)) u_qer_dev_b (.pclk(pclk),
    .presetn(presetn), .link(link_b.dev), .enc_a(2'b00), .enc_b(2'b00), .enc_ok(2'b11),
    .gain_p(bp), .gain_i(bi), .gain_d(bd), .full_speed_pulse_rate(br));
  qer_link_sva u_qer_link_sva (.pclk(pclk), .presetn(presetn), .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_stat(input int ch);
    return {enc_ok[ch], 4'h0, ov[ch], dir[ch], un[ch]};
  endfunction : exp_stat
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // One transfer; an idle cycle follows so a strobe never changes twice at one edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    @(posedge pclk);
  endtask : apb
  task automatic host_cmd(input logic [7:0] code);
    logic [31:0] q;
    int k;
    apb(1'b1, OFS_CTRL, {16'h0000, DEF_UNIT_ADDR, code}, q, e);
    k = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0000_0000, q, e);
      k++;
    end while (q[STAT_DONE] !== 1'b1 && k < 100);
    chk_word({29'h0, q[2:0]}, 32'h0000_0002, "stat");
    apb(1'b0, OFS_RXVAL, 32'h0000_0000, rv, e);
    apb(1'b0, OFS_RXINFO, 32'h0000_0000, q, e);
    ri = q[7:0];
  endtask : host_cmd
  // Gray steps, forward order 00,10,11,01 on (a,b)
  task automatic step(input int ch, input bit up, input int n, input int per);
    repeat (n) begin
      ph[ch] = up ? ph[ch] + 2'd1 : ph[ch] - 2'd1;
      enc_a[ch] <= ^ph[ch];
      enc_b[ch] <= ph[ch][1];
      if (up) begin
        if (cnt[ch] == CNT_MAX) ov[ch] = 1'b1;
        cnt[ch]++;
      end else begin
        if (cnt[ch] == 32'h0000_0000) un[ch] = 1'b1;
        cnt[ch]--;
      end
      dir[ch] = !up;
      repeat (per) @(posedge pclk);
    end
  endtask : step
  task automatic chk_pos(input int ch);
    host_cmd(ch ? CMD_POS2 : CMD_POS1);
    chk_word(rv, cnt[ch], "count");
    chk_word({24'h0, ri}, {24'h0, exp_stat(ch)}, "status");
    un[ch] = 1'b0;
    ov[ch] = 1'b0;
  endtask : chk_pos
  task automatic send_b(input logic [7:0] code, input logic [7:0] bad);
    logic [7:0] s;
    logic [7:0] b;
    s = DEF_UNIT_ADDR + code;
    link_b.h2d_valid <= 1'b1;
    link_b.h2d_data <= DEF_UNIT_ADDR;
    @(posedge pclk);
    link_b.h2d_data <= code;
    @(posedge pclk);
    repeat (16) begin
      b = 8'(rnd());
      s += b;
      pay = {pay[119:0], b};
      link_b.h2d_data <= b;
      @(posedge pclk);
    end
    link_b.h2d_data <= (s & CRC_MASK) ^ bad;
    @(posedge pclk);
    link_b.h2d_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : send_b
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {enc_a, enc_b, un, ov, dir} = '0;
    enc_ok = 2'b11;
    cnt = '{32'h0, 32'h0};
    ph = '{2'd0, 2'd0};
    link_b.h2d_valid = 1'b0;
    link_b.h2d_data = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int m = 0; m < 2; m++) begin
      chk_word(gain_p[m], DEF_P, "p");
      chk_word(gain_i[m], DEF_I, "i");
      chk_word(gain_d[m], DEF_D, "d");
      chk_word(speed_rate[m], DEF_RATE, "rate");
    end
    $display("test defaults done");
    // Wrap down then up; motor two reports a failed encoder
    enc_ok <= 2'b01;
    repeat (8) @(posedge pclk);
    for (int m = 0; m < 2; m++) begin
      step(m, 1'b0, 1, 6);
      chk_pos(m);
      chk_pos(m);
      step(m, 1'b1, 1, 6);
      chk_pos(m);
      step(m, rnd() % 2, 1 + rnd() % 6, 6);
      chk_pos(m);
    end
    enc_ok <= 2'b11;
    host_cmd(CMD_CLR);
    cnt = '{32'h0, 32'h0};
    chk_pos(0);
    chk_pos(1);
    $display("test counters done");
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        gv[k] = rnd();
        apb(1'b1, OFS_TX0 + 8'(4 * k), gv[k], rv, e);
      end
      host_cmd(m ? CMD_PID2 : CMD_PID1);
      repeat (4) @(posedge pclk);
      chk_word(gain_d[m], gv[0], "d load");
      chk_word(gain_p[m], gv[1], "p load");
      chk_word(gain_i[m], gv[2], "i load");
      chk_word(speed_rate[m], gv[3], "rate load");
    end
    $display("test gain load done");
    fork
      step(0, 1'b1, 300, 10);
      begin
        repeat (2200) @(posedge pclk);
        host_cmd(CMD_SPD1);
        chk_word(rv, 32'(SEC_T / 10), "per second");
        chk_word({24'h0, ri}, 32'h0, "forward");
        host_cmd(CMD_HSP1);
        chk_word(rv, 32'(HSP_T / 10), "fast");
      end
    join
    step(1, 1'b0, 3, 6);
    repeat (2 * SEC_T + 50) @(posedge pclk);
    host_cmd(CMD_SPD2);
    chk_word({rv[7:0], ri}, 16'h0001, "idle backward");
    host_cmd(CMD_HSP2);
    chk_word(rv, 32'h0, "fast idle");
    chk_pos(0);
    chk_pos(1);
    $display("test speed done");
    apb(1'b0, 8'h20, 32'h0000_0000, rv, e);
    chk_word(rv, 32'h0, "unmapped");
    chk_word({31'h0, e}, 32'h1, "slverr");
    send_b(CMD_PID1, 8'h01);
    chk_word(bd[0], DEF_D, "bad crc kept");
    send_b(CMD_PID1, 8'h00);
    chk_word(bd[0], pay[127:96], "good crc d");
    chk_word(br[0], pay[31:0], "good crc rate");
    $display("test link faults done");
    finish_test();
  end
endmodule : tb_top
